// >>> design/mode_config_map.svh
// register offsets, field positions, reset values and timing counts for the mode configuration bank
`ifndef MODE_CONFIG_MAP_SVH
`define MODE_CONFIG_MAP_SVH

// printed offsets (0xf1, 0xf5) are not multiples of four, so each is kept as a register index
`define IDX_FUNC_F0 8'hf0
`define IDX_FUNC_F1 8'hf1
`define IDX_FUNC_F2 8'hf2
`define IDX_FLOPPY_A 8'hf4
`define IDX_FLOPPY_B 8'hf5
// function windows: byte address = (window base) + 4 * index
`define WIN_FLOPPY 12'h000
`define WIN_PARALLEL 12'h400
`define WIN_UART_ONE 12'h800
`define WIN_UART_TWO 12'hc00
// side-band control and status word, outside every function window
`define ADDR_SIDEBAND 16'h1000
`define SB_TO_ACK_BIT 0
`define SB_TO_STATUS_BIT 1
`define SB_STATUS_READ_BIT 2

`define RST_PARALLEL_MODE 8'h3c
`define RST_PARALLEL_EXTRA 8'h00
`define RST_UART_ONE 8'h00
`define RST_UART_TWO 8'h00
`define RST_IR_OPTIONS 8'h02
`define RST_IR_BLANK 8'h03
`define RST_FLOPPY 8'h00

`define MASK_FLOPPY 8'h5b
`define MASK_PARALLEL_EXTRA 8'h10
`define MASK_UART_ONE 8'h83
`define MASK_UART_TWO 8'h23
`define MASK_IR_OPTIONS 8'h7f

`define BIT_PRECOMP_DISABLE 6
`define BIT_PP_IRQ_TYPE 7
`define BIT_TIMEOUT_SELECT 4
`define BIT_MIDI 0
`define BIT_HIGH_SPEED 1
`define BIT_SHARE_IRQ 7
`define BIT_TX_TWO_TRISTATE 5
`define BIT_RX_POL 0
`define BIT_TX_POL 1
`define BIT_HALF_DUPLEX 2
`define BIT_IR_LOCATION 6

`define CLK_PERIOD_NS 100
`define BLANK_STEP_US 100
`define BLANK_STEP_CYCLES ((`BLANK_STEP_US * 1000) / `CLK_PERIOD_NS)
`define PULSE_LEN_NS 200
`define PULSE_LEN_CYCLES (((`PULSE_LEN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS))

`endif

// >>> design/mode_config_pkg.sv
// types of the mode configuration bank
package mode_config_pkg;

    typedef enum logic [2:0] {
        pp_spp = 3'b000,
        pp_epp19 = 3'b001,
        pp_ecp = 3'b010,
        pp_ecp_epp19 = 3'b011,
        pp_printer = 3'b100,
        pp_epp17 = 3'b101,
        pp_res6 = 3'b110,
        pp_ecp_epp17 = 3'b111
    } pp_mode_type;

    typedef enum logic [2:0] {
        ir_standard = 3'b000,
        ir_irda = 3'b001,
        ir_ask = 3'b010,
        ir_res3 = 3'b011,
        ir_res4 = 3'b100,
        ir_res5 = 3'b101,
        ir_res6 = 3'b110,
        ir_res7 = 3'b111
    } ir_mode_type;

    // bus state per channel: idle -> write or read respond -> idle
    typedef enum logic [1:0] {
        bus_idle = 2'b00,
        bus_wr_resp = 2'b01,
        bus_rd_resp = 2'b11
    } bus_state_type;

    typedef struct packed {
        bus_state_type wst;
        bus_state_type rst;
        logic aw_got;
        logic w_got;
        logic [15:0] awaddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
        logic [7:0] parallel_mode;
        logic [7:0] parallel_extra;
        logic [7:0] uart_one_mode;
        logic [7:0] uart_two_mode;
        logic [7:0] ir_options;
        logic [7:0] ir_blank;
        logic [7:0] floppy_a;
        logic [7:0] floppy_b;
        logic epp_timeout;
        logic status_read_pend;
        logic [2:0] pulse_cnt;
        logic pp_irq;
        logic pp_irq_oe;
        logic ack_n_prev;
        logic uart_one_irq;
        logic uart_two_irq;
        logic tx_pin;
        logic tx_pin_oe;
        logic alt_tx_pin;
        logic ir_rx;
        logic ir_rx_blank;
        logic [9:0] step_cnt;
        logic [7:0] blank_cnt;
        logic [7:0] ctl_out;
    } state_type;

endpackage : mode_config_pkg

// >>> design/mode_config_bank.sv
// per-function mode configuration register bank with AXI4-Lite access
// Behaviour
// - floppy registers: drive type in bits 1:0, rate table in bits 4:3
// - floppy bit 6 set disables write precompensation, clear enables it
// - second floppy register matches first; bits 2, 5, 7 read zero
// - parallel mode field encodes printer, spp, epp and ecp variants, printer default
// - parallel mode bits 6:3 hold ecp fifo threshold, default 0111
// - interrupt type zero: parallel interrupt follows acknowledge in epp-style modes
// - interrupt type one: interrupt pulses low then releases to high impedance
// - ecp modes use level interrupt; type bit ignored in printer and spp
// - timeout flag clears on write one, or after status read when selected
// - uart mode bit 0 enables midi, default off
// - uart mode bit 1 enables high speed, default off
// - uart one bit 7 makes both uarts share one interrupt
// - sharing with both assigned asserts both interrupts on either event
// - uart two bit 5: transmit pin idles driven high, or high impedance
// - transmit idle bit resets only on standby power-on reset
// - infrared bit 0 selects receive polarity, active high default
// - infrared bit 1 selects transmit polarity, active low default
// - infrared bit 2 selects full duplex or half duplex
// - infrared mode field: standard, irda, amplitude keyed; others reserved
// - infrared bit 6 routes over uart two pins or alternate pins
// - half duplex blank time counts 100 us steps after transmit
//
// The AXI4-Lite register port was left to the implementer.
`timescale 1ns/100ps
`default_nettype none
`include "mode_config_map.svh"

module mode_config_bank
    import mode_config_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic standby_resetn,
    input wire logic [15:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [15:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic printer_acknowledge_n,
    input wire logic pp_event,
    input wire logic epp_timeout_set,
    input wire logic uart_one_event,
    input wire logic uart_two_event,
    input wire logic uart_one_irq_assigned,
    input wire logic uart_two_irq_assigned,
    input wire logic uart_two_tx_data,
    input wire logic ir_tx_data,
    input wire logic ir_tx_active,
    input wire logic uart_two_rx_pin,
    input wire logic alt_infrared_rx_pin,
    output logic pp_irq_out,
    output logic pp_irq_oe,
    output logic uart_one_irq,
    output logic uart_two_irq,
    output logic uart_two_tx_pin,
    output logic uart_two_tx_oe,
    output logic alt_infrared_tx_pin,
    output logic ir_rx_data,
    output logic ir_rx_blanked,
    output logic epp_timeout_flag,
    output logic [7:0] mode_controls
);

    state_type q;
    state_type d;
    logic tx_idle_tristate_q;
    logic tx_idle_tristate_d;

    // map a byte address to a register slot; 4'hf means unmapped
    function automatic logic [3:0] decode(input logic [15:0] addr);
        logic [7:0] idx;
        logic [11:0] win;
        idx = addr[9:2];
        win = {addr[11:10], 10'h000};
        decode = 4'hf;
        if (addr == `ADDR_SIDEBAND) begin
            decode = 4'h8;
        end else if (addr[15:12] == 4'h0 && addr[1:0] == 2'b00) begin
            if (win == `WIN_FLOPPY && idx == `IDX_FLOPPY_A) decode = 4'h6;
            if (win == `WIN_FLOPPY && idx == `IDX_FLOPPY_B) decode = 4'h7;
            if (win == `WIN_PARALLEL && idx == `IDX_FUNC_F0) decode = 4'h0;
            if (win == `WIN_PARALLEL && idx == `IDX_FUNC_F1) decode = 4'h1;
            if (win == `WIN_UART_ONE && idx == `IDX_FUNC_F0) decode = 4'h2;
            if (win == `WIN_UART_TWO && idx == `IDX_FUNC_F0) decode = 4'h3;
            if (win == `WIN_UART_TWO && idx == `IDX_FUNC_F1) decode = 4'h4;
            if (win == `WIN_UART_TWO && idx == `IDX_FUNC_F2) decode = 4'h5;
        end
    endfunction : decode

    function automatic logic [31:0] read_word(input logic [3:0] slot, input state_type s, input logic txm);
        read_word = 32'h0000_0000;
        unique case (slot)
            4'h0: read_word = {24'h000000, s.parallel_mode};
            4'h1: read_word = {24'h000000, s.parallel_extra & `MASK_PARALLEL_EXTRA};
            4'h2: read_word = {24'h000000, s.uart_one_mode & `MASK_UART_ONE};
            4'h3: read_word = {24'h000000, (s.uart_two_mode & `MASK_UART_TWO) | {2'b00, txm, 5'h00}};
            4'h4: read_word = {24'h000000, s.ir_options & `MASK_IR_OPTIONS};
            4'h5: read_word = {24'h000000, s.ir_blank};
            4'h6: read_word = {24'h000000, s.floppy_a & `MASK_FLOPPY};
            4'h7: read_word = {24'h000000, s.floppy_b & `MASK_FLOPPY};
            4'h8: read_word = {29'h0, s.status_read_pend, s.epp_timeout, 1'b0};
            default: read_word = 32'h0000_0000;
        endcase
    endfunction : read_word

    logic wr_fire;
    logic [3:0] wr_slot;
    logic [7:0] wbyte;
    logic [3:0] rd_slot;
    pp_mode_type pp_mode;
    logic ecp_family;
    logic plain_mode;
    logic pp_pulse_start;
    logic share;
    logic ir_active_low_rx;
    logic rx_raw;
    logic ack_edge;
    logic status_read_done;

    always_comb begin
        d = q;
        tx_idle_tristate_d = tx_idle_tristate_q;
        wr_fire = 1'b0;
        wbyte = q.wdata[7:0];
        wr_slot = decode(q.awaddr);
        rd_slot = decode(s_axi_araddr);
        status_read_done = 1'b0;

        // write channel: address and data accepted independently, response after both
        d.awready = 1'b0;
        d.wready = 1'b0;
        if (q.wst == bus_idle) begin
            if (!q.aw_got && s_axi_awvalid && !q.awready) begin
                d.awready = 1'b1;
                d.awaddr = s_axi_awaddr;
                d.aw_got = 1'b1;
            end
            if (!q.w_got && s_axi_wvalid && !q.wready) begin
                d.wready = 1'b1;
                d.wdata = s_axi_wdata;
                d.wstrb = s_axi_wstrb;
                d.w_got = 1'b1;
            end
            if (q.aw_got && q.w_got) begin
                wr_fire = 1'b1;
                d.wst = bus_wr_resp;
                d.bvalid = 1'b1;
                d.bresp = (wr_slot == 4'hf) ? 2'b10 : 2'b00;
                d.aw_got = 1'b0;
                d.w_got = 1'b0;
            end
        end else if (q.bvalid && s_axi_bready) begin
            d.bvalid = 1'b0;
            d.wst = bus_idle;
        end

        // register writes honour byte lane 0 only; bits above it read as zero
        if (wr_fire && q.wstrb[0]) begin
            unique case (wr_slot)
                4'h0: d.parallel_mode = wbyte;
                4'h1: d.parallel_extra = wbyte & `MASK_PARALLEL_EXTRA;
                4'h2: d.uart_one_mode = wbyte & `MASK_UART_ONE;
                4'h3: begin
                    d.uart_two_mode = wbyte & `MASK_UART_TWO;
                    tx_idle_tristate_d = wbyte[`BIT_TX_TWO_TRISTATE];
                end
                4'h4: d.ir_options = wbyte & `MASK_IR_OPTIONS;
                4'h5: d.ir_blank = wbyte;
                4'h6: d.floppy_a = wbyte & `MASK_FLOPPY;
                4'h7: d.floppy_b = wbyte & `MASK_FLOPPY;
                default: d.ctl_out = q.ctl_out;
            endcase
        end

        // read channel
        d.arready = 1'b0;
        if (q.rst == bus_idle) begin
            if (s_axi_arvalid && !q.arready) begin
                d.arready = 1'b1;
                d.rvalid = 1'b1;
                d.rdata = read_word(rd_slot, q, tx_idle_tristate_q);
                d.rresp = (rd_slot == 4'hf) ? 2'b10 : 2'b00;
                d.rst = bus_rd_resp;
                d.status_read_pend = (rd_slot == 4'h8);
            end
        end else if (q.rvalid && s_axi_rready) begin
            d.rvalid = 1'b0;
            d.rst = bus_idle;
            // trailing edge of the status read
            status_read_done = q.status_read_pend;
            d.status_read_pend = 1'b0;
        end

        // epp timeout flag: set beats clear
        if (q.parallel_extra[`BIT_TIMEOUT_SELECT]) begin
            if (status_read_done) d.epp_timeout = 1'b0;
        end else if (wr_fire && q.wstrb[0] && wr_slot == 4'h8 && wbyte[`SB_TO_ACK_BIT]) begin
            d.epp_timeout = 1'b0;
        end
        if (epp_timeout_set) d.epp_timeout = 1'b1;

        // parallel interrupt
        pp_mode = pp_mode_type'(q.parallel_mode[2:0]);
        ecp_family = (pp_mode == pp_ecp) || (pp_mode == pp_ecp_epp19) || (pp_mode == pp_ecp_epp17);
        plain_mode = (pp_mode == pp_printer) || (pp_mode == pp_spp);
        d.ack_n_prev = printer_acknowledge_n;
        ack_edge = q.ack_n_prev && !printer_acknowledge_n;
        pp_pulse_start = 1'b0;
        if (q.pulse_cnt != 3'd0) begin
            d.pulse_cnt = q.pulse_cnt - 3'd1;
        end
        if (ecp_family && !pp_event) begin
            d.pp_irq = 1'b0;
            d.pp_irq_oe = 1'b1;
        end else if (ecp_family) begin
            d.pp_irq = 1'b1;
            d.pp_irq_oe = 1'b1;
        end else if (plain_mode || !q.parallel_mode[`BIT_PP_IRQ_TYPE]) begin
            d.pp_irq = !printer_acknowledge_n;
            d.pp_irq_oe = 1'b1;
        end else begin
            pp_pulse_start = ack_edge;
            if (pp_pulse_start) d.pulse_cnt = 3'(`PULSE_LEN_CYCLES);
            d.pp_irq = 1'b0;
            d.pp_irq_oe = pp_pulse_start || (q.pulse_cnt > 3'd1);
        end

        // uart interrupts
        share = q.uart_one_mode[`BIT_SHARE_IRQ];
        if (share) begin
            d.uart_one_irq = (uart_one_event || uart_two_event) && uart_one_irq_assigned;
            d.uart_two_irq = (uart_one_event || uart_two_event) && uart_two_irq_assigned;
        end else begin
            d.uart_one_irq = uart_one_event;
            d.uart_two_irq = uart_two_event;
        end

        // infrared routing and polarity
        ir_active_low_rx = q.ir_options[`BIT_RX_POL];
        if (ir_mode_type'(q.ir_options[5:3]) == ir_standard) begin
            d.tx_pin = uart_two_tx_data;
            d.tx_pin_oe = !(tx_idle_tristate_q && uart_two_tx_data);
            d.alt_tx_pin = 1'b0;
            rx_raw = uart_two_rx_pin;
        end else begin
            rx_raw = q.ir_options[`BIT_IR_LOCATION] ? alt_infrared_rx_pin : uart_two_rx_pin;
            d.tx_pin = q.ir_options[`BIT_IR_LOCATION] ? uart_two_tx_data : (ir_tx_data ^ q.ir_options[`BIT_TX_POL]);
            d.tx_pin_oe = 1'b1;
            d.alt_tx_pin = q.ir_options[`BIT_IR_LOCATION] ? (ir_tx_data ^ q.ir_options[`BIT_TX_POL]) : 1'b0;
        end
        d.ir_rx = rx_raw ^ ir_active_low_rx;

        // half duplex blanking
        if (ir_tx_active) begin
            d.blank_cnt = q.ir_blank;
            d.step_cnt = 10'(`BLANK_STEP_CYCLES - 1);
        end else if (q.blank_cnt != 8'h00) begin
            if (q.step_cnt == 10'd0) begin
                d.step_cnt = 10'(`BLANK_STEP_CYCLES - 1);
                d.blank_cnt = q.blank_cnt - 8'h01;
            end else begin
                d.step_cnt = q.step_cnt - 10'd1;
            end
        end
        d.ir_rx_blank = q.ir_options[`BIT_HALF_DUPLEX] && (ir_tx_active || d.blank_cnt != 8'h00);

        d.ctl_out = {q.floppy_a[`BIT_PRECOMP_DISABLE], q.floppy_b[`BIT_PRECOMP_DISABLE],
                     q.uart_one_mode[`BIT_MIDI], q.uart_one_mode[`BIT_HIGH_SPEED],
                     q.uart_two_mode[`BIT_MIDI], q.uart_two_mode[`BIT_HIGH_SPEED],
                     q.ir_options[`BIT_HALF_DUPLEX], q.parallel_extra[`BIT_TIMEOUT_SELECT]};
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            q <= '0;
            q.parallel_mode <= `RST_PARALLEL_MODE;
            q.parallel_extra <= `RST_PARALLEL_EXTRA;
            q.uart_one_mode <= `RST_UART_ONE;
            q.uart_two_mode <= `RST_UART_TWO;
            q.ir_options <= `RST_IR_OPTIONS;
            q.ir_blank <= `RST_IR_BLANK;
            q.floppy_a <= `RST_FLOPPY;
            q.floppy_b <= `RST_FLOPPY;
            q.ack_n_prev <= 1'b1;
            q.pp_irq_oe <= 1'b1;
        end else begin
            q <= d;
        end
    end

    // standby-powered bit survives main reset
    always_ff @(posedge aclk) begin
        if (!standby_resetn) begin
            tx_idle_tristate_q <= 1'b0;
        end else begin
            tx_idle_tristate_q <= tx_idle_tristate_d;
        end
    end

    assign s_axi_awready = q.awready;
    assign s_axi_wready = q.wready;
    assign s_axi_bvalid = q.bvalid;
    assign s_axi_bresp = q.bresp;
    assign s_axi_arready = q.arready;
    assign s_axi_rvalid = q.rvalid;
    assign s_axi_rresp = q.rresp;
    assign s_axi_rdata = q.rdata;
    assign pp_irq_out = q.pp_irq;
    assign pp_irq_oe = q.pp_irq_oe;
    assign uart_one_irq = q.uart_one_irq;
    assign uart_two_irq = q.uart_two_irq;
    assign uart_two_tx_pin = q.tx_pin;
    assign uart_two_tx_oe = q.tx_pin_oe;
    assign alt_infrared_tx_pin = q.alt_tx_pin;
    assign ir_rx_data = q.ir_rx;
    assign ir_rx_blanked = q.ir_rx_blank;
    assign epp_timeout_flag = q.epp_timeout;
    assign mode_controls = q.ctl_out;

endmodule : mode_config_bank
`default_nettype wire

// >>> testbench/mode_config_chk.sv
// assertions for the mode config bank
`timescale 1ns/100ps
`default_nettype none
module mode_config_chk (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awready,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic epp_timeout_set,
    input wire logic epp_timeout_flag,
    input wire logic pp_irq_out,
    input wire logic pp_irq_oe,
    input wire logic ir_tx_active,
    input wire logic ir_rx_blanked,
    input wire logic [7:0] mode_controls
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    sequence low_driven;
        pp_irq_oe && !pp_irq_out;
    endsequence
    sequence r_waiting;
        s_axi_rvalid && !s_axi_rready;
    endsequence
    aw_pulse_a: assert property (s_axi_awready |=> !s_axi_awready)
        else $error("awready too long");
    ar_answer_a: assert property (s_axi_arready |-> s_axi_rvalid)
        else $error("no read answer");
    b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("bvalid dropped");
    r_hold_a: assert property (r_waiting |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read answer moved");
    b_cause_a: assert property ($rose(s_axi_bvalid) |-> $past(s_axi_awready) || $past(s_axi_wready))
        else $error("stray bvalid");
    pulse_shape_a: assert property ($rose(pp_irq_oe) && !pp_irq_out |=> low_driven ##1 !pp_irq_oe)
        else $error("bad irq pulse");
    to_set_a: assert property (epp_timeout_set |=> epp_timeout_flag)
        else $error("flag not set");
    to_clear_a: assert property ($fell(epp_timeout_flag) |->
        $past(s_axi_wready) || $past(s_axi_wready, 2) || ($past(s_axi_rvalid) && $past(s_axi_rready)))
        else $error("stray flag clear");
    blank_tx_a: assert property (mode_controls[1] && ir_tx_active |=> ir_rx_blanked)
        else $error("rx not blanked");
endmodule : mode_config_chk

bind mode_config_bank mode_config_chk mode_config_chk_inst (.*);
`default_nettype wire

// >>> testbench/logical_device_mode_config_tb.sv
// testbench for the mode configuration bank
`timescale 1ns/100ps
`default_nettype none
module logical_device_mode_config_tb;
    logic aclk = 1'b0;
    logic aresetn, standby_resetn;
    logic [15:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, rs;
    logic s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic printer_acknowledge_n, pp_event, epp_timeout_set, uart_one_event, uart_two_event;
    logic uart_one_irq_assigned, uart_two_irq_assigned, uart_two_tx_data, ir_tx_data, ir_tx_active;
    logic uart_two_rx_pin, alt_infrared_rx_pin, pp_irq_out, pp_irq_oe, uart_one_irq, uart_two_irq;
    logic uart_two_tx_pin, uart_two_tx_oe, alt_infrared_tx_pin, ir_rx_data, ir_rx_blanked, epp_timeout_flag;
    logic [7:0] mode_controls;
    int miscompares = 0, checks_done = 0;
    localparam logic [15:0] addr_tab [8] = '{16'h03d0, 16'h03d4, 16'h07c0, 16'h07c4, 16'h0bc0, 16'h0fc0,
        16'h0fc4, 16'h0fc8};
    localparam logic [7:0] rst_tab [8] = '{8'h00, 8'h00, 8'h3c, 8'h00, 8'h00, 8'h00, 8'h02, 8'h03};
    localparam logic [7:0] mask_tab [8] = '{8'h5b, 8'h5b, 8'hff, 8'h10, 8'h83, 8'h23, 8'h7f, 8'hff};
    localparam logic [2:0] mode_tab [7] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h7};

    mode_config_bank mode_config_bank_inst (.*);

    always #50 aclk = ~aclk;

    task automatic tally_and_finish();
        $display("checks %0d errors %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : tally_and_finish

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            miscompares++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic hang_check(input int n);
        if (n >= 50) begin
            miscompares++;
            $display("Error at %0t: timeout", $time);
            tally_and_finish();
        end
    endtask : hang_check

    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        int n;
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (n = 0; n < 50 && s_axi_bvalid !== 1'b1; n++) begin
            @(posedge aclk);
            if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
        end
        hang_check(n);
        rs = s_axi_bresp;
        s_axi_bready <= 1'b0;
        @(posedge aclk);
    endtask : wr

    task automatic rd_reg(input logic [15:0] a);
        int n;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (n = 0; n < 50 && s_axi_rvalid !== 1'b1; n++) begin
            @(posedge aclk);
            if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
        end
        hang_check(n);
        rd = s_axi_rdata;
        rs = s_axi_rresp;
        s_axi_rready <= 1'b0;
        @(posedge aclk);
    endtask : rd_reg

    task automatic test_registers();
        for (int i = 0; i < 8; i++) begin
            rd_reg(addr_tab[i]);
            check(rd, {24'h0, rst_tab[i]});
        end
        check({24'h0, mode_controls}, 32'h0);
        for (int i = 0; i < 8; i++) begin
            wr(addr_tab[i], 8'hff);
            check({30'h0, rs}, 32'h0);
            rd_reg(addr_tab[i]);
            check(rd, {24'h0, mask_tab[i]});
        end
        check({24'h0, mode_controls}, 32'hff);
        for (int i = 0; i < 8; i++) begin
            wr(addr_tab[i], 8'h00);
            rd_reg(addr_tab[i]);
            check(rd, 32'h0);
        end
        wr(16'h2000, 8'h01);
        check({30'h0, rs}, 32'h2);
        rd_reg(16'h2000);
        check({rd[29:0], rs}, 32'h2);
        $display("registers done");
    endtask : test_registers

    task automatic test_pp_irq();
        int cnt;
        for (int i = 0; i < 7; i++) begin
            printer_acknowledge_n <= 1'b0;
            pp_event <= 1'b0;
            wr(16'h07c0, {1'b0, 4'h7, mode_tab[i]});
            repeat (3) @(posedge aclk);
            check(32'({pp_irq_oe, pp_irq_out}), 32'({1'b1, ~mode_tab[i][1]}));
            printer_acknowledge_n <= 1'b1;
            pp_event <= 1'b1;
            repeat (3) @(posedge aclk);
            check(32'({pp_irq_oe, pp_irq_out}), 32'({1'b1, mode_tab[i][1]}));
        end
        pp_event <= 1'b0;
        printer_acknowledge_n <= 1'b0;
        wr(16'h07c0, 8'hbc);
        repeat (3) @(posedge aclk);
        check(32'({pp_irq_oe, pp_irq_out}), 32'h3);
        wr(16'h07c0, 8'hb9);
        printer_acknowledge_n <= 1'b1;
        repeat (3) @(posedge aclk);
        printer_acknowledge_n <= 1'b0;
        cnt = 0;
        repeat (8) begin
            @(posedge aclk);
            if (pp_irq_oe === 1'b1 && pp_irq_out === 1'b0) cnt++;
        end
        check(32'(cnt), 32'h2);
        check(32'(pp_irq_oe), 32'h0);
        $display("pp irq done");
    endtask : test_pp_irq

    task automatic test_timeout();
        for (int sel = 0; sel < 2; sel++) begin
            wr(16'h07c4, sel[0] ? 8'h10 : 8'h00);
            check(32'(mode_controls[0]), 32'(sel));
            epp_timeout_set <= 1'b1;
            @(posedge aclk);
            epp_timeout_set <= 1'b0;
            repeat (2) @(posedge aclk);
            wr(16'h1000, 8'h01);
            check(32'(epp_timeout_flag), 32'(sel));
            rd_reg(16'h1000);
            check(32'(rd[1]), 32'(sel));
            check(32'(epp_timeout_flag), 32'h0);
        end
        $display("timeout done");
    endtask : test_timeout

    task automatic test_uart_share();
        uart_one_irq_assigned <= 1'b1;
        uart_two_irq_assigned <= 1'b1;
        uart_one_event <= 1'b1;
        wr(16'h0bc0, 8'h00);
        repeat (2) @(posedge aclk);
        check(32'({uart_one_irq, uart_two_irq}), 32'h2);
        wr(16'h0bc0, 8'h80);
        repeat (2) @(posedge aclk);
        check(32'({uart_one_irq, uart_two_irq}), 32'h3);
        uart_two_irq_assigned <= 1'b0;
        uart_one_event <= 1'b0;
        uart_two_event <= 1'b1;
        repeat (2) @(posedge aclk);
        check(32'({uart_one_irq, uart_two_irq}), 32'h2);
        uart_two_event <= 1'b0;
        $display("share done");
    endtask : test_uart_share

    task automatic test_tx_idle();
        uart_two_tx_data <= 1'b1;
        wr(16'h0fc0, 8'h20);
        repeat (2) @(posedge aclk);
        check(32'(uart_two_tx_oe), 32'h0);
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        rd_reg(16'h0fc0);
        check(rd, 32'h20);
        standby_resetn <= 1'b0;
        @(posedge aclk);
        standby_resetn <= 1'b1;
        repeat (2) @(posedge aclk);
        rd_reg(16'h0fc0);
        check(rd, 32'h0);
        check(32'(uart_two_tx_oe), 32'h1);
        $display("tx idle done");
    endtask : test_tx_idle

    task automatic test_infrared();
        int cnt;
        int lo [3] = '{1001, 3, 0};
        int hi [3] = '{1006, 5, 0};
        logic [7:0] opt [3] = '{8'h49, 8'h4a, 8'h51};
        ir_tx_data <= 1'b1;
        for (int i = 0; i < 3; i++) begin
            wr(16'h0fc4, opt[i]);
            repeat (2) @(posedge aclk);
            check(32'({alt_infrared_tx_pin, ir_rx_data}), (i == 1) ? 32'h0 : 32'h3);
        end
        for (int i = 0; i < 3; i++) begin
            wr(16'h0fc8, (i == 1) ? 8'h00 : 8'h01);
            wr(16'h0fc4, (i == 2) ? 8'h40 : 8'h44);
            ir_tx_active <= 1'b1;
            cnt = 0;
            for (int n = 0; n < 1100; n++) begin
                @(posedge aclk);
                if (n == 2) ir_tx_active <= 1'b0;
                if (ir_rx_blanked === 1'b1) cnt++;
            end
            check(32'(cnt >= lo[i] && cnt <= hi[i]), 32'h1);
        end
        $display("ir done");
    endtask : test_infrared

    initial begin
        aresetn = 1'b0;
        standby_resetn = 1'b0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 64'h0;
        s_axi_wstrb = 4'hf;
        {pp_event, epp_timeout_set, uart_one_event, uart_two_event, uart_one_irq_assigned} = 5'h00;
        {uart_two_irq_assigned, uart_two_tx_data, ir_tx_data, ir_tx_active, uart_two_rx_pin, alt_infrared_rx_pin} = 6'h0;
        printer_acknowledge_n = 1'b1;
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        standby_resetn <= 1'b1;
        repeat (2) @(posedge aclk);
        test_registers();
        test_pp_irq();
        test_tx_idle();
        test_timeout();
        test_uart_share();
        test_infrared();
        tally_and_finish();
    end
endmodule : logical_device_mode_config_tb
`default_nettype wire
